// [design/fws_consts.svh]
// Constants for the flash write, suspend and lock controller: register offsets,
// field positions, reset values and pin timing.
// Assumes a 10 MHz pclk and one 8-bit asynchronous flash part on the pins.
`ifndef FWS_CONSTS_SVH
`define FWS_CONSTS_SVH

// Register byte offsets on APB
`define FWS_REG_CTRL 8'h00
`define FWS_REG_CMD 8'h04
`define FWS_REG_ADDR 8'h08
`define FWS_REG_WDATA 8'h0C
`define FWS_REG_STATUS 8'h10
`define FWS_REG_RDATA 8'h14

// CTRL fields
`define FWS_CTRL_OVR 0
`define FWS_CTRL_AUTOCLR 1
`define FWS_CTRL_PD 2
`define FWS_CTRL_RESET 3'h0

// STATUS fields
`define FWS_ST_BUSY 0
`define FWS_ST_REFUSED 1
`define FWS_ST_SUSP 2
`define FWS_ST_UNDET 3
`define FWS_ST_ERRSEEN 4
`define FWS_ST_SR_LSB 8

// Device status byte bit positions
`define FWS_SR_READY 7
`define FWS_SR_ERASE_ERR 5
`define FWS_SR_PROG_ERR 4
`define FWS_SR_VPP_ERR 3
`define FWS_SR_WSUSP 2
`define FWS_SR_LOCK_ERR 1

// Pin timing
`define FWS_CLK_NS 100
`define FWS_STROBE_NS 200
`define FWS_SETTLE_NS 500
`define FWS_STROBE_CYC ((`FWS_STROBE_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_SETTLE_CYC ((`FWS_SETTLE_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
// Read strobe also covers the two-flop data synchroniser
`define FWS_READ_CYC (`FWS_STROBE_CYC + 2)

`endif

// [design/fws_ctrl.sv]
// Host-side controller for an asynchronous flash: APB registers in, flash pins out.
// Assumes the flash answers on its pins only; ready/busy and data are asynchronous.
// Function
// - Only read, status, resume while suspended
// - Lock set is setup then confirm
// - Check program error, clear status after
// - Check erase error, clear status after
// - Aborted clear leaves bits undetermined
//
// The implementer's own choices: the APB register port and the register addresses.
`include "fws_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module fws_ctrl #(
   parameter int AW = 19,
   // Command codes; values are arbitrary defaults
   parameter logic [7:0] C_READ_ARRAY = 8'h01,
   parameter logic [7:0] C_READ_STATUS = 8'h02,
   parameter logic [7:0] C_CLEAR_STATUS = 8'h03,
   parameter logic [7:0] C_WRITE_SETUP = 8'h04,
   parameter logic [7:0] C_SUSPEND = 8'h05,
   parameter logic [7:0] C_RESUME = 8'h06,
   parameter logic [7:0] C_LOCK_SETUP = 8'h07,
   parameter logic [7:0] C_BLOCK_CONFIRM = 8'h08,
   parameter logic [7:0] C_MASTER_CONFIRM = 8'h09,
   parameter logic [7:0] C_CLEAR_CONFIRM = 8'h0A
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [AW-1:0] flash_addr,
   output logic [7:0] flash_dq_o,
   output logic flash_dq_oe,
   input wire logic [7:0] flash_dq_i,
   output logic flash_ce_n,
   output logic flash_oe_n,
   output logic flash_we_n,
   output logic flash_pwrdn_n,
   output logic flash_lock_ovr,
   input wire logic flash_ready_busy
);
   typedef enum logic [2:0] {S_IDLE, S_WLO, S_WHI, S_WAIT, S_RLO, S_RHI} fws_state_t;

   localparam logic [7:0] STROBE = 8'(`FWS_STROBE_CYC);
   localparam logic [7:0] SETTLE = 8'(`FWS_SETTLE_CYC);
   localparam logic [7:0] RDCYC = 8'(`FWS_READ_CYC);

   fws_state_t st_q, st_d;
   fws_pkg::fws_op_t op_q, op_in;
   logic [7:0] tmr_q, tmr_d;
   logic widx_q, widx_d, clr_q, clr_d;
   logic [2:0] ctrl_q;
   logic [AW-1:0] addr_q, susp_addr_q;
   logic [7:0] wdata_q, sr_q, rdata_q;
   logic refused_q, undet_q, susp_q, errseen_q;
   logic [7:0] dq_s1, dq_s2;
   logic rb_s1, rb_s2;
   logic pready_q, pslverr_q;
   logic [31:0] prdata_q;
   logic busy, two_cyc, long_op, unmapped, wr_en, cmd_wr, allowed, start, abort;
   logic rd_done, err_now, rd_is_sr, susp_ok;
   logic [7:0] code;

   // Two flops on every asynchronous pin input
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dq_s1 <= 8'h00;
         dq_s2 <= 8'h00;
         rb_s1 <= 1'b0;
         rb_s2 <= 1'b0;
      end else if (clk_en) begin
         dq_s1 <= flash_dq_i;
         dq_s2 <= dq_s1;
         rb_s1 <= flash_ready_busy;
         rb_s2 <= rb_s1;
      end
   end

   assign busy = (st_q != S_IDLE);
   assign op_in = fws_pkg::fws_op_t'(pwdata[3:0]);
   assign two_cyc = (op_q == fws_pkg::FWS_OP_BYTE_WRITE) ||
                    (op_q == fws_pkg::FWS_OP_SET_BLOCK_LOCK) ||
                    (op_q == fws_pkg::FWS_OP_SET_MASTER_LOCK) ||
                    (op_q == fws_pkg::FWS_OP_CLEAR_LOCKS);
   assign long_op = two_cyc || (op_q == fws_pkg::FWS_OP_SUSPEND) ||
                    (op_q == fws_pkg::FWS_OP_RESUME);
   assign rd_is_sr = long_op || (op_q == fws_pkg::FWS_OP_READ_STATUS);
   assign err_now = sr_q[`FWS_SR_ERASE_ERR] | sr_q[`FWS_SR_PROG_ERR] |
                    sr_q[`FWS_SR_VPP_ERR] | sr_q[`FWS_SR_LOCK_ERR];
   assign abort = ctrl_q[`FWS_CTRL_PD];
   // A suspend has to cut into the ready wait of a byte write, or it could never land
   assign susp_ok = (st_q == S_WAIT) && (op_q == fws_pkg::FWS_OP_BYTE_WRITE) &&
                    (op_in == fws_pkg::FWS_OP_SUSPEND);

   // APB decode
   assign unmapped = !(paddr == `FWS_REG_CTRL || paddr == `FWS_REG_CMD ||
                       paddr == `FWS_REG_ADDR || paddr == `FWS_REG_WDATA ||
                       paddr == `FWS_REG_STATUS || paddr == `FWS_REG_RDATA);
   assign wr_en = psel && penable && pready_q && pwrite && !pslverr_q;
   assign cmd_wr = wr_en && (paddr == `FWS_REG_CMD);

   // While suspended only array reads elsewhere, plain reads at any address, status reads and resume go out
   always_comb begin
      allowed = (!busy || susp_ok) && !abort && (pwdata[3:0] <= 4'h9);
      if (susp_q) begin
         allowed = allowed && ((op_in == fws_pkg::FWS_OP_READ_ARRAY &&
                                addr_q != susp_addr_q) ||
                               op_in == fws_pkg::FWS_OP_READ_STATUS ||
                               op_in == fws_pkg::FWS_OP_RESUME ||
                               op_in == fws_pkg::FWS_OP_READ);
      end
   end
   assign start = cmd_wr && allowed;

   // Setup code first, confirm or data second
   always_comb begin
      code = C_READ_STATUS;
      case (op_q)
         fws_pkg::FWS_OP_READ_ARRAY: code = C_READ_ARRAY;
         fws_pkg::FWS_OP_READ_STATUS: code = C_READ_STATUS;
         fws_pkg::FWS_OP_CLEAR_STATUS: code = C_CLEAR_STATUS;
         fws_pkg::FWS_OP_BYTE_WRITE: code = widx_q ? wdata_q : C_WRITE_SETUP;
         fws_pkg::FWS_OP_SUSPEND: code = C_SUSPEND;
         fws_pkg::FWS_OP_RESUME: code = C_RESUME;
         fws_pkg::FWS_OP_SET_BLOCK_LOCK: code = widx_q ? C_BLOCK_CONFIRM : C_LOCK_SETUP;
         fws_pkg::FWS_OP_SET_MASTER_LOCK: code = widx_q ? C_MASTER_CONFIRM : C_LOCK_SETUP;
         fws_pkg::FWS_OP_CLEAR_LOCKS: code = widx_q ? C_CLEAR_CONFIRM : C_LOCK_SETUP;
         default: code = C_READ_STATUS;
      endcase
      if (clr_q) begin
         code = C_CLEAR_STATUS;
      end
   end

   assign rd_done = (st_q == S_RLO) && (tmr_q == 8'h01);

   always_comb begin
      st_d = st_q;
      tmr_d = (tmr_q > 8'h01) ? tmr_q - 8'h01 : tmr_q;
      widx_d = widx_q;
      clr_d = clr_q;
      case (st_q)
         S_IDLE: begin
            if (start) begin
               widx_d = 1'b0;
               clr_d = 1'b0;
               st_d = (op_in == fws_pkg::FWS_OP_READ) ? S_RLO : S_WLO;
               tmr_d = (op_in == fws_pkg::FWS_OP_READ) ? RDCYC : STROBE;
            end
         end
         S_WLO: begin
            if (tmr_q == 8'h01) begin
               st_d = S_WHI;
               tmr_d = STROBE;
            end
         end
         S_WHI: begin
            if (tmr_q == 8'h01) begin
               if (!clr_q && !widx_q && two_cyc) begin
                  widx_d = 1'b1;
                  st_d = S_WLO;
                  tmr_d = STROBE;
               end else if (clr_q || op_q == fws_pkg::FWS_OP_CLEAR_STATUS) begin
                  st_d = S_IDLE;
               end else if (long_op) begin
                  st_d = S_WAIT;
                  tmr_d = SETTLE;
               end else begin
                  st_d = S_RLO;
                  tmr_d = RDCYC;
               end
            end
         end
         S_WAIT: begin
            // Wait for the part to report ready, then read status
            if (start) begin
               widx_d = 1'b0;
               st_d = S_WLO;
               tmr_d = STROBE;
            end else if (tmr_q == 8'h01 && rb_s2) begin
               st_d = S_RLO;
               tmr_d = RDCYC;
            end
         end
         S_RLO: begin
            if (tmr_q == 8'h01) begin
               st_d = S_RHI;
               tmr_d = STROBE;
            end
         end
         S_RHI: begin
            if (tmr_q == 8'h01) begin
               // Clear errors after a failed long operation
               if (long_op && ctrl_q[`FWS_CTRL_AUTOCLR] && err_now) begin
                  clr_d = 1'b1;
                  st_d = S_WLO;
                  tmr_d = STROBE;
               end else begin
                  st_d = S_IDLE;
               end
            end
         end
         default: st_d = S_IDLE;
      endcase
      // Power-down ends any sequence; the part is in reset
      if (abort) begin
         st_d = S_IDLE;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= S_IDLE;
         tmr_q <= 8'h00;
         widx_q <= 1'b0;
         clr_q <= 1'b0;
         op_q <= fws_pkg::FWS_OP_READ;
      end else if (clk_en) begin
         st_q <= st_d;
         tmr_q <= tmr_d;
         widx_q <= widx_d;
         clr_q <= clr_d;
         if (start) begin
            op_q <= op_in;
         end
      end
   end

   // Strobes, chip enable and dq enable follow next state; every pin comes straight from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flash_ce_n <= 1'b1;
         flash_we_n <= 1'b1;
         flash_oe_n <= 1'b1;
         flash_dq_oe <= 1'b0;
         flash_dq_o <= 8'h00;
         flash_addr <= '0;
         flash_pwrdn_n <= 1'b0;
         flash_lock_ovr <= 1'b0;
      end else if (clk_en) begin
         flash_ce_n <= (st_d == S_IDLE);
         flash_we_n <= (st_d != S_WLO);
         flash_oe_n <= (st_d != S_RLO);
         flash_dq_oe <= (st_d == S_WLO) || (st_d == S_WHI);
         flash_dq_o <= code;
         flash_addr <= addr_q;
         flash_pwrdn_n <= !ctrl_q[`FWS_CTRL_PD];
         // Two-state override select; no intermediate level exists
         flash_lock_ovr <= ctrl_q[`FWS_CTRL_OVR];
      end
   end

   // Captured data and tracked device state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= 8'h00;
         sr_q <= 8'h00;
         susp_q <= 1'b0;
         susp_addr_q <= '0;
      end else if (clk_en) begin
         if (rd_done) begin
            rdata_q <= dq_s2;
            if (rd_is_sr && !clr_q) begin
               sr_q <= dq_s2;
            end
         end
         if (rd_done && op_q == fws_pkg::FWS_OP_SUSPEND &&
             dq_s2[`FWS_SR_WSUSP] && dq_s2[`FWS_SR_READY]) begin
            susp_q <= 1'b1;
            susp_addr_q <= addr_q;
         end else if ((start && op_in == fws_pkg::FWS_OP_RESUME) || abort) begin
            susp_q <= 1'b0;
         end
      end
   end

   // Sticky flags; hardware set wins over a software clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         refused_q <= 1'b0;
         undet_q <= 1'b0;
         errseen_q <= 1'b0;
      end else if (clk_en) begin
         if (cmd_wr && !allowed) begin
            refused_q <= 1'b1;
         end else if (wr_en && paddr == `FWS_REG_STATUS && pwdata[`FWS_ST_REFUSED]) begin
            refused_q <= 1'b0;
         end
         if (abort && busy && op_q == fws_pkg::FWS_OP_CLEAR_LOCKS) begin
            undet_q <= 1'b1;
         end else if (st_q == S_RHI && tmr_q == 8'h01 && !clr_q &&
                      op_q == fws_pkg::FWS_OP_CLEAR_LOCKS && !err_now) begin
            undet_q <= 1'b0; // A clean repeat restores known values
         end else if (wr_en && paddr == `FWS_REG_STATUS && pwdata[`FWS_ST_UNDET]) begin
            undet_q <= 1'b0;
         end
         if (st_q == S_RHI && long_op && !clr_q && err_now) begin
            errseen_q <= 1'b1;
         end else if (wr_en && paddr == `FWS_REG_STATUS && pwdata[`FWS_ST_ERRSEEN]) begin
            errseen_q <= 1'b0;
         end
      end
   end

   // APB slave: answer in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `FWS_CTRL_RESET;
         addr_q <= '0;
         wdata_q <= 8'h00;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else if (clk_en) begin
         if (psel && !penable) begin
            pready_q <= 1'b1;
            pslverr_q <= unmapped;
            case (paddr)
               `FWS_REG_CTRL: prdata_q <= {29'h0, ctrl_q};
               `FWS_REG_ADDR: prdata_q <= 32'(addr_q);
               `FWS_REG_WDATA: prdata_q <= {24'h0, wdata_q};
               `FWS_REG_STATUS: prdata_q <= {16'h0, sr_q, 3'h0, errseen_q, undet_q,
                                             susp_q, refused_q, busy};
               `FWS_REG_RDATA: prdata_q <= {24'h0, rdata_q};
               default: prdata_q <= 32'h0000_0000;
            endcase
         end else if (pready_q) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
         end
         if (wr_en && paddr == `FWS_REG_CTRL) begin
            ctrl_q <= pwdata[2:0];
         end
         // Address and data hold still while a sequence runs
         if (wr_en && paddr == `FWS_REG_ADDR && !busy) begin
            addr_q <= pwdata[AW-1:0];
         end
         if (wr_en && paddr == `FWS_REG_WDATA && !busy) begin
            wdata_q <= pwdata[7:0];
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn || !clk_en);

   sequence we_pulse;
      (!flash_we_n) [*2] ##1 flash_we_n;
   endsequence

   a_refuse_when_busy: assert property (cmd_wr && busy && !susp_ok && !abort
      |=> refused_q && busy)
      else $error("command accepted while busy");
   a_suspend_cut: assert property (start && busy |=> st_q == S_WLO &&
      op_q == fws_pkg::FWS_OP_SUSPEND)
      else $error("suspend did not cut into the wait");
   a_suspend_filter: assert property (cmd_wr && susp_q && !busy && !abort &&
      op_in == fws_pkg::FWS_OP_CLEAR_STATUS |=> refused_q && st_q == S_IDLE)
      else $error("disallowed command issued while suspended");
   a_suspend_track: assert property (rd_done && op_q == fws_pkg::FWS_OP_SUSPEND &&
      dq_s2[`FWS_SR_WSUSP] && dq_s2[`FWS_SR_READY] |=> susp_q)
      else $error("suspend not recorded");
   a_two_cycle_seq: assert property (disable iff (!presetn || !clk_en || abort)
      st_q == S_WHI && tmr_q == 8'h01 && !widx_q && two_cyc && !clr_q
      |=> (st_q == S_WLO && widx_q) ##0 we_pulse)
      else $error("confirm write missing");
   // A power-down may cut a strobe short
   a_we_width: assert property (disable iff (!presetn || !clk_en || abort)
      $fell(flash_we_n) |-> we_pulse)
      else $error("write strobe width wrong");
   a_no_oe_we: assert property (!(!flash_oe_n && !flash_we_n))
      else $error("read and write strobes overlap");
   a_wait_ready: assert property (st_q == S_WAIT && !rb_s2 && !abort && !start
      |=> st_q == S_WAIT)
      else $error("left wait before ready");
   a_auto_clear: assert property (st_q == S_RHI && tmr_q == 8'h01 && long_op && !clr_q &&
      ctrl_q[`FWS_CTRL_AUTOCLR] && err_now && !abort
      |=> clr_q ##1 (!flash_we_n && flash_dq_o == C_CLEAR_STATUS))
      else $error("error not cleared");
   a_undet_set: assert property (abort && busy && op_q == fws_pkg::FWS_OP_CLEAR_LOCKS
      |=> undet_q && !busy)
      else $error("aborted clear not flagged");
endmodule
`default_nettype wire

// [design/fws_pkg.sv]
// Types shared by the flash write, suspend and lock controller.
// Assumes nothing beyond a SystemVerilog compiler.
package fws_pkg;
   typedef enum logic [3:0] {
      FWS_OP_READ = 4'h0,
      FWS_OP_READ_ARRAY = 4'h1,
      FWS_OP_READ_STATUS = 4'h2,
      FWS_OP_CLEAR_STATUS = 4'h3,
      FWS_OP_BYTE_WRITE = 4'h4,
      FWS_OP_SUSPEND = 4'h5,
      FWS_OP_RESUME = 4'h6,
      FWS_OP_SET_BLOCK_LOCK = 4'h7,
      FWS_OP_SET_MASTER_LOCK = 4'h8,
      FWS_OP_CLEAR_LOCKS = 4'h9
   } fws_op_t;
endpackage

// [verification/fws_flash_model.sv]
// Behavioural flash part: command decoder, status byte, lock bits, write suspend.
// Assumes command codes equal to the controller's default parameters.
`timescale 1ns/1ns
`default_nettype none
module fws_flash_model #(
   parameter int AW = 19,
   parameter int BUSY_CYC = 30
) (
   input wire logic [AW-1:0] addr,
   input wire logic [7:0] dq_in,
   output logic [7:0] dq_out,
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic pwrdn_n,
   input wire logic lock_ovr,
   input wire logic supply_low,
   output logic ready_busy
);
   logic [7:0] mem [logic [AW-1:0]];
   logic [7:0] blk = 8'h00, sr = 8'h00, pend = 8'h00, val, last = 8'h00, wd;
   logic [AW-1:0] wa;
   logic master = 1'b0, stat = 1'b0, susp = 1'b0, susp_req = 1'b0, wop = 1'b0, clr = 1'b0;
   int cnt = 0;
   wire logic [2:0] bi = addr[AW-1:AW-3];
   assign ready_busy = (cnt == 0) || susp;
   always @(posedge we_n) begin
      if (!ce_n && pwrdn_n === 1'b1) begin
         stat = 1'b1;
         if (pend == 8'h04) begin
            pend = 8'h00;
            if (blk[bi] && !lock_ovr) sr = sr | 8'h12;
            else begin
               {wa, wd, wop} = {addr, dq_in, 1'b1};
               cnt = BUSY_CYC;
            end
         end else if (pend == 8'h07) begin
            pend = 8'h00;
            cnt = BUSY_CYC;
            clr = dq_in == 8'h0A;
            if (dq_in == 8'h08 && master && !lock_ovr) sr = sr | 8'h12;
            else if (dq_in == 8'h08) blk[bi] = 1'b1;
            else if (dq_in == 8'h09 && !lock_ovr) sr = sr | 8'h12;
            else if (dq_in == 8'h09) master = 1'b1;
            else if (clr && supply_low) sr = sr | 8'h28;
            else if (clr && master && !lock_ovr) sr = sr | 8'h22;
            else if (clr) blk = 8'h00;
            else sr = sr | 8'h30;
         end else if (!susp || dq_in inside {8'h01, 8'h02, 8'h06}) begin
            pend = dq_in;
            if (dq_in == 8'h01) stat = 1'b0;
            if (dq_in == 8'h03) sr = sr & 8'hC5;
            if (dq_in == 8'h05 && cnt > 0) susp_req = 1'b1;
            if (dq_in == 8'h06 && susp) {susp, sr[2]} = 2'b00;
         end
      end
   end
   // Abort during a lock clear scrambles the bits; only a repeat restores them
   always @(negedge pwrdn_n) begin
      if (cnt > 0 && clr) blk = blk ^ 8'h5A;
      cnt = 0;
      {susp, susp_req, stat, wop, clr, pend, sr} = 21'h0;
   end
   always #100 begin
      if (cnt > 0 && !susp) begin
         // Halts only on a checkpoint, never mid-step
         if (susp_req && cnt % 4 == 0) {susp, susp_req, sr[2]} = 3'b101;
         else cnt = cnt - 1;
         if (cnt == 0) begin
            if (wop) mem[wa] = wd;
            {wop, clr} = 2'b00;
         end
      end
   end
   always @(addr, stat, ready_busy, sr, ce_n, oe_n, last) begin
      val = stat ? {ready_busy, sr[6:0]} : (mem.exists(addr) ? mem[addr] : 8'hFF);
      // Released bus shows the inverse so a stale value cannot pass
      dq_out = (!ce_n && !oe_n) ? val : ~last;
   end
   always @(posedge oe_n) last = val;
endmodule
`default_nettype wire

// [verification/tb_top.sv]
// Self-checking bench: APB master tasks, flash model, read scoreboard.
// Assumes the controller's register map header and default command codes.
`include "fws_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, dq_oe, ce_n, oe_n, we_n, pwrdn_n, ovr, rb;
   logic supply_low = 1'b0;
   logic [18:0] faddr, a1, a2;
   logic [7:0] dq_o, dq_i, d1, d2;
   logic [33:0] exq [$];
   logic [33:0] e;
   int n_errors = 0;
   int n_tests = 0;
   int seed = 73;
   int i;
   logic [15:0] steps [13] = '{
      16'h1480,
      16'h1780,
      16'h1492,
      16'h9480,
      16'h0892,
      16'h8880,
      16'h2792,
      16'hA780,
      16'h2492,
      16'h09A2,
      16'h8980,
      16'h2480,
      16'h3792
   };
   fws_ctrl fws_ctrl_i (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .flash_addr(faddr), .flash_dq_o(dq_o),
      .flash_dq_oe(dq_oe), .flash_dq_i(dq_i), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
      .flash_we_n(we_n), .flash_pwrdn_n(pwrdn_n), .flash_lock_ovr(ovr),
      .flash_ready_busy(rb));
   fws_flash_model fws_flash_model_i (.addr(faddr), .dq_in(dq_o), .dq_out(dq_i), .ce_n(ce_n),
      .oe_n(oe_n), .we_n(we_n), .pwrdn_n(pwrdn_n), .lock_ovr(ovr), .supply_low(supply_low),
      .ready_busy(rb));
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   always @(negedge pclk) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
         e = exq.pop_front();
         if (e[33] === 1'b1) begin
            n_tests++;
            if ({pslverr, prdata} !== e[32:0]) begin
               n_errors++;
               $display("BAD %0t exp %h got %h", $time, e[32:0], {pslverr, prdata});
            end
         end
      end
   end
   task automatic results();
      if (n_errors == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic timeout();
      n_errors++;
      results();
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      logic rdy;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      rdy = 1'b0;
      for (k = 0; k < 20 && !rdy; k++) begin
         // Answer taken at the very edge that samples pready high
         @(posedge pclk);
         rdy = pready === 1'b1;
         q = prdata;
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
      if (!rdy) timeout();
   endtask
   task automatic rd(input logic [7:0] a, input logic care, input logic [32:0] ex);
      exq.push_back({care, ex});
      apb(1'b0, a, 32'h0);
   endtask
   task automatic stat(input logic [7:0] sr, input logic [4:0] f);
      rd(`FWS_REG_STATUS, 1'b1, {17'h0, sr, 3'h0, f});
   endtask
   task automatic start(input fws_pkg::fws_op_t op, input logic [18:0] a, input logic [7:0] d);
      apb(1'b1, `FWS_REG_ADDR, {13'h0, a});
      apb(1'b1, `FWS_REG_WDATA, {24'h0, d});
      apb(1'b1, `FWS_REG_CMD, {28'h0, op});
   endtask
   task automatic idle();
      int k;
      for (k = 0; k < 400; k++) begin
         rd(`FWS_REG_STATUS, 1'b0, 33'h0);
         if (q[0] === 1'b0) break;
      end
      if (k == 400) timeout();
   endtask
   task automatic run(input fws_pkg::fws_op_t op, input logic [18:0] a, input logic [7:0] d);
      start(op, a, d);
      idle();
   endtask
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(`FWS_REG_CTRL, 1'b1, 33'h0);
      rd(`FWS_REG_CMD, 1'b1, 33'h0);
      rd(`FWS_REG_RDATA, 1'b1, 33'h0);
      stat(8'h00, 5'h00);
      rd(8'h18, 1'b1, {1'b1, 32'h0});
      a1 = {3'd4, 16'($random(seed))};
      d1 = 8'($random(seed));
      run(fws_pkg::FWS_OP_BYTE_WRITE, a1, d1);
      stat(8'h80, 5'h00);
      run(fws_pkg::FWS_OP_READ_ARRAY, a1, 8'h00);
      rd(`FWS_REG_RDATA, 1'b1, {25'h0, d1});
      // Command while busy and an out-of-range op are both refused
      start(fws_pkg::FWS_OP_BYTE_WRITE, a1 + 19'h1, 8'($random(seed)));
      apb(1'b1, `FWS_REG_CMD, 32'h2);
      idle();
      stat(8'h80, 5'h02);
      apb(1'b1, `FWS_REG_STATUS, 32'h2);
      stat(8'h80, 5'h00);
      apb(1'b1, `FWS_REG_CMD, 32'hF);
      stat(8'h80, 5'h02);
      apb(1'b1, `FWS_REG_STATUS, 32'h2);
      start(fws_pkg::FWS_OP_CLEAR_LOCKS, 19'h0, 8'h00);
      apb(1'b1, `FWS_REG_CTRL, 32'h4);
      idle();
      stat(8'h80, 5'h08);
      apb(1'b1, `FWS_REG_CTRL, 32'h0);
      run(fws_pkg::FWS_OP_CLEAR_LOCKS, 19'h0, 8'h00);
      stat(8'h80, 5'h00);
      // Suspend lands while the part is still busy with the write
      a2 = {3'd5, 16'($random(seed))};
      d2 = 8'($random(seed));
      start(fws_pkg::FWS_OP_BYTE_WRITE, a2, d2);
      repeat (8) @(posedge pclk);
      apb(1'b1, `FWS_REG_CMD, 32'h5);
      idle();
      stat(8'h84, 5'h04);
      start(fws_pkg::FWS_OP_READ_ARRAY, a2, 8'h00);
      apb(1'b1, `FWS_REG_CMD, 32'h3);
      stat(8'h84, 5'h06);
      apb(1'b1, `FWS_REG_STATUS, 32'h2);
      run(fws_pkg::FWS_OP_READ_ARRAY, a1, 8'h00);
      rd(`FWS_REG_RDATA, 1'b1, {25'h0, d1});
      run(fws_pkg::FWS_OP_RESUME, a2, 8'h00);
      stat(8'h80, 5'h00);
      run(fws_pkg::FWS_OP_READ_ARRAY, a2, 8'h00);
      rd(`FWS_REG_RDATA, 1'b1, {25'h0, d2});
      for (i = 0; i < 13; i++) begin
         apb(1'b1, `FWS_REG_CTRL, {31'h0, steps[i][15]});
         run(fws_pkg::fws_op_t'(steps[i][11:8]), {steps[i][14:12], 16'($random(seed))},
            8'($random(seed)));
         // Any error byte after a long op marks errseen; every error step runs without the lock override
         stat(steps[i][7:0], {steps[i][7:0] != 8'h80, 4'h0});
         if (steps[i][7:0] != 8'h80) begin
            run(fws_pkg::FWS_OP_READ_STATUS, 19'h0, 8'h00);
            stat(steps[i][7:0], 5'h10);
            run(fws_pkg::FWS_OP_CLEAR_STATUS, 19'h0, 8'h00);
            run(fws_pkg::FWS_OP_READ_STATUS, 19'h0, 8'h00);
            apb(1'b1, `FWS_REG_STATUS, 32'h10);
            stat(8'h80, 5'h00);
         end
      end
      // Low supply clear fails; auto clear then wipes the part's error bits
      supply_low <= 1'b1;
      apb(1'b1, `FWS_REG_CTRL, 32'h3);
      run(fws_pkg::FWS_OP_CLEAR_LOCKS, 19'h0, 8'h00);
      stat(8'hA8, 5'h10);
      supply_low <= 1'b0;
      run(fws_pkg::FWS_OP_READ_STATUS, 19'h0, 8'h00);
      stat(8'h80, 5'h10);
      results();
   end
endmodule
`default_nettype wire
